// *** logic/airc_pkg.sv ***
// constants and types for the interrupt and reset control register block
`default_nettype none

package airc_pkg;

  // apb decode
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] REG_OFF       = 12'h000;
  localparam logic [11:0] WORD_MASK     = 12'hffc;

  // key halfword
  localparam int          KEY_LSB       = 16;
  localparam logic [15:0] KEY_UNLOCK    = 16'h05fa;
  localparam logic [15:0] KEY_READBACK  = 16'hfa05;

  // field positions
  localparam int          BIT_BYTE_ORD  = 15;
  localparam int          SPLIT_LSB     = 8;
  localparam int          SPLIT_MSB     = 10;
  localparam int          BIT_SYSRST    = 2;
  localparam int          BIT_CLR_ACT   = 1;
  localparam int          BIT_LOCAL_RST = 0;

  // reset values
  localparam logic        BYTE_ORD_LITTLE = 1'b0;
  localparam logic [2:0]  SPLIT_RESET     = 3'h0;

  // priority fields: three implemented bits at the top of eight
  localparam int          PRI_BITS      = 3;
  localparam int          PRI_FIELD_W   = 8;
  localparam int          PRI_PAD       = PRI_FIELD_W - PRI_BITS;
  localparam int          NUM_REQ       = 4;
  localparam int          IDX_W         = 2;

  // warm reset pulse length
  localparam int          CLK_PERIOD_PS = 8000;
  localparam int          WARM_HOLD_NS  = 64;
  localparam int          WARM_HOLD_CYC = (WARM_HOLD_NS * 1000 + CLK_PERIOD_PS - 1)
                                          / CLK_PERIOD_PS;
  localparam logic [3:0]  WARM_LAST     = 4'(WARM_HOLD_CYC - 1);

  // warm reset sequencer
  typedef enum logic [2:0] {
    WS_IDLE = 3'b001,
    WS_HOLD = 3'b010,
    WS_DONE = 3'b100
  } airc_wstate_t;

endpackage : airc_pkg

`default_nettype wire

// *** logic/airc_split.sv ***
// splits one priority field into pre-emption and subpriority parts
`default_nettype none

module airc_split
  import airc_pkg::*;
(
  input  wire logic [PRI_BITS-1:0]    i_pri,
  input  wire logic [2:0]             i_split,
  output logic      [PRI_FIELD_W-1:0] o_preempt,
  output logic      [PRI_FIELD_W-1:0] o_sub
);

  logic [PRI_FIELD_W-1:0] field;
  logic [PRI_FIELD_W:0]   mask9;
  logic [3:0]             shamt;

  // unimplemented low bits always read as zero
  assign field = {i_pri, PRI_PAD'(0)};  // RQ12

  // code n leaves 7-n pre-emption bits on top and n+1 sub bits below
  assign shamt     = 4'({1'b0, i_split}) + 4'h1;  // RQ3
  assign mask9     = 9'h1ff << shamt;  // RQ3
  assign o_preempt = field & mask9[PRI_FIELD_W-1:0];  // RQ3
  assign o_sub     = field & ~mask9[PRI_FIELD_W-1:0];  // RQ3

  // the sub part never reaches above bit n, the pre-emption part never below n+1
  chk_split_sub: assert final (o_sub <= (8'hff >> (3'h7 - i_split))) // RQ3
    else $error("sub part wider than the split allows");
  chk_split_pre: assert final ((o_preempt & (8'hff >> (3'h7 - i_split))) == 8'h00) // RQ3
    else $error("pre-emption part reaches into the sub bits");
  chk_split_lowzero: assert final ( // RQ12
    o_preempt[PRI_PAD-1:0] == '0 && o_sub[PRI_PAD-1:0] == '0)
    else $error("unimplemented priority bits not zero");

endmodule : airc_split

`default_nettype wire

// *** logic/airc_ctrl.sv ***
// key protected interrupt grouping and reset control register with apb access
//
// Operation
// (RQ1) writes need unlock key in upper halfword; reads return fixed readback constant
// (RQ2) byte order flag reports memory order; this product is little endian
// (RQ3) split code n gives 7-n pre-emption bits and n+1 sub bits
// (RQ4) split applies to all priorities; only pre-emption part decides pre-emption
// (RQ5) keyed write of one to reset request bit raises reset request output
// (RQ6) asserted reset request makes the device perform a warm reset
// (RQ7) the warm reset returns the reset request bit to zero
// (RQ8) clear-active bit erases active exception state, self clears, zero ignored
// (RQ9) software reinitialises the stack after clearing active exceptions
// (RQ10) local reset bit resets system except debug units; zero does nothing
// (RQ11) local reset bit reads back as zero after triggering
// (RQ12) priority fields keep three top bits; lower bits read zero
// (RQ13) wrong key write changes nothing and triggers no action
// (RQ14) reserved bits 14..11 and 7..3 read zero, writes ignored
`default_nettype none

module airc_ctrl
  import airc_pkg::*;
(
  input  wire logic                         I_CLK,
  input  wire logic                         I_RST_B,
  input  wire logic                         I_PSEL,
  input  wire logic                         I_PENABLE,
  input  wire logic                         I_PWRITE,
  input  wire logic [ADDR_W-1:0]            I_PADDR,
  input  wire logic [31:0]                  I_PWDATA,
  output logic      [31:0]                  O_PRDATA,
  output logic                              O_PREADY,
  output logic                              O_PSLVERR,
  input  wire logic [NUM_REQ-1:0]           I_REQ_PEND,
  input  wire logic [NUM_REQ*PRI_BITS-1:0]  I_REQ_PRI,
  input  wire logic                         I_ACT_VALID,
  input  wire logic [PRI_BITS-1:0]          I_ACT_PRI,
  output logic                              O_WIN_VALID,
  output logic      [IDX_W-1:0]             O_WIN_IDX,
  output logic                              O_PREEMPT,
  output logic      [2:0]                   O_PRI_SPLIT,
  output logic                              O_SYSRESET_REQ,
  output logic                              O_WARM_RESET,
  output logic                              O_CLEAR_ACTIVE,
  output logic                              O_LOCAL_RESET
);

  typedef struct packed {
    airc_wstate_t     wst;
    logic [3:0]       wcnt;
    logic [2:0]       split;
    logic             sysrst;
    logic             clr;
    logic             lrst;
    logic [31:0]      rdata;
    logic             win_valid;
    logic [IDX_W-1:0] win_idx;
    logic             preempt;
  } airc_state_t;

  localparam airc_state_t ST_RESET = '{
    wst:       WS_IDLE,
    wcnt:      4'h0,
    split:     SPLIT_RESET,
    sysrst:    1'b0,
    clr:       1'b0,
    lrst:      1'b0,
    rdata:     32'h0000_0000,
    win_valid: 1'b0,
    win_idx:   2'h0,
    preempt:   1'b0
  };

  airc_state_t s_r;
  airc_state_t s_nxt;

  logic                   hit;
  logic                   setup_rd;
  logic                   access;
  logic                   wr_ok;
  logic [31:0]            reg_view;
  logic [PRI_FIELD_W-1:0] req_pre [NUM_REQ];
  logic [PRI_FIELD_W-1:0] req_sub [NUM_REQ];
  logic [PRI_FIELD_W-1:0] act_pre;
  logic [PRI_FIELD_W-1:0] act_sub;

  // address decode; only the one aligned word is mapped
  assign hit      = (I_PADDR & WORD_MASK) == REG_OFF;
  assign setup_rd = I_PSEL & ~I_PENABLE & ~I_PWRITE;
  assign access   = I_PSEL & I_PENABLE;
  // a write lands only with the unlock key in the top halfword
  assign wr_ok    = access & I_PWRITE & hit
                    & (I_PWDATA[31:KEY_LSB] == KEY_UNLOCK); // RQ1 RQ13

  // read image: fixed key, fixed byte order, reserved bits zero, action bits
  // clear and local reset always read zero since they only live one cycle
  always_comb begin
    reg_view                        = 32'h0000_0000; // RQ14
    reg_view[31:KEY_LSB]            = KEY_READBACK; // RQ1
    reg_view[BIT_BYTE_ORD]          = BYTE_ORD_LITTLE; // RQ2
    reg_view[SPLIT_MSB:SPLIT_LSB]   = s_r.split;
    reg_view[BIT_SYSRST]            = s_r.sysrst;
    reg_view[BIT_CLR_ACT]           = 1'b0; // RQ8
    reg_view[BIT_LOCAL_RST]         = 1'b0; // RQ11
  end

  // one splitter per pending request plus one for the running level
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REQ; gi++) begin : g_req
      airc_split u_split (
        .i_pri     (I_REQ_PRI[gi*PRI_BITS +: PRI_BITS]),
        .i_split   (s_r.split),
        .o_preempt (req_pre[gi]),
        .o_sub     (req_sub[gi])
      );
    end
  endgenerate

  airc_split u_act_split (
    .i_pri     (I_ACT_PRI),
    .i_split   (s_r.split),
    .o_preempt (act_pre),
    .o_sub     (act_sub)
  );

  // next state of the whole block
  always_comb begin
    logic                   found;
    logic [IDX_W-1:0]       best;
    logic [PRI_FIELD_W-1:0] best_pre;
    logic [PRI_FIELD_W-1:0] best_sub;
    found    = 1'b0;
    best     = 2'h0;
    best_pre = 8'h00;
    best_sub = 8'h00;
    s_nxt    = s_r;

    // read data is captured in the setup phase so it leaves a flip-flop
    if (setup_rd) begin
      s_nxt.rdata = hit ? reg_view : 32'h0000_0000;
    end

    // action bits are one-cycle pulses; they self clear
    s_nxt.clr  = 1'b0; // RQ8
    s_nxt.lrst = 1'b0; // RQ11

    // keyed write: split stored, actions fired only by ones
    if (wr_ok) begin
      s_nxt.split = I_PWDATA[SPLIT_MSB:SPLIT_LSB];
      s_nxt.clr   = I_PWDATA[BIT_CLR_ACT]; // RQ8
      s_nxt.lrst  = I_PWDATA[BIT_LOCAL_RST]; // RQ10
    end

    // local reset returns the core grouping to default, debug is not ours
    if (s_r.lrst) begin
      s_nxt.split = SPLIT_RESET; // RQ10
    end

    // warm reset sequencer
    unique case (s_r.wst)
      WS_IDLE: begin
        s_nxt.wcnt = 4'h0;
        if (s_r.sysrst) begin
          s_nxt.wst = WS_HOLD; // RQ6
        end
      end
      WS_HOLD: begin
        s_nxt.wcnt = s_r.wcnt + 4'h1;
        if (s_r.wcnt == WARM_LAST) begin
          s_nxt.wst    = WS_DONE;
          s_nxt.sysrst = 1'b0; // RQ7
          s_nxt.split  = SPLIT_RESET;
        end
      end
      WS_DONE: begin
        s_nxt.wcnt = 4'h0;
        s_nxt.wst  = WS_IDLE;
      end
      default: begin
        s_nxt.wcnt = 4'h0;
        s_nxt.wst  = WS_IDLE;
      end
    endcase

    // a new request written in the clearing cycle wins over the clear
    if (wr_ok && I_PWDATA[BIT_SYSRST]) begin
      s_nxt.sysrst = 1'b1; // RQ5
    end

    // pick the pending request: lowest pre-emption, then sub, then index
    for (int k = 0; k < NUM_REQ; k++) begin
      if (I_REQ_PEND[k]) begin
        if (!found || req_pre[k] < best_pre ||
            (req_pre[k] == best_pre && req_sub[k] < best_sub)) begin // RQ4
          found    = 1'b1;
          best     = IDX_W'(k);
          best_pre = req_pre[k];
          best_sub = req_sub[k];
        end
      end
    end
    s_nxt.win_valid = found;
    s_nxt.win_idx   = best;
    // only the pre-emption part can interrupt the running handler
    s_nxt.preempt   = found & (~I_ACT_VALID | (best_pre < act_pre)); // RQ4
  end

  // state register
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      s_r <= ST_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs; ready is immediate, so every access takes two cycles
  assign O_PREADY       = access;
  assign O_PSLVERR      = access & ~hit;
  assign O_PRDATA       = s_r.rdata;
  assign O_PRI_SPLIT    = s_r.split;
  assign O_SYSRESET_REQ = s_r.sysrst; // RQ5
  assign O_WARM_RESET   = (s_r.wst == WS_HOLD); // RQ6
  assign O_CLEAR_ACTIVE = s_r.clr; // RQ8
  assign O_LOCAL_RESET  = s_r.lrst; // RQ10
  assign O_WIN_VALID    = s_r.win_valid;
  assign O_WIN_IDX      = s_r.win_idx;
  assign O_PREEMPT      = s_r.preempt;

  // the stack is left to software after a clear; nothing here restores it

  // checks; the helper terms below are read only by the properties
  logic rd_access;
  logic bad_key_wr;
  logic warm_last;
  // the last hold cycle is the one place where the warm reset rewrites the split
  assign warm_last  = (s_r.wst == WS_HOLD) && (s_r.wcnt == WARM_LAST);
  assign rd_access  = access & ~I_PWRITE & hit;
  assign bad_key_wr = access & I_PWRITE & hit & (I_PWDATA[31:KEY_LSB] != KEY_UNLOCK);

  chk_key_readback: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ1
    rd_access |-> O_PRDATA[31:KEY_LSB] == KEY_READBACK)
    else $error("key readback wrong");

  chk_byte_order: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ2
    rd_access |-> O_PRDATA[BIT_BYTE_ORD] == BYTE_ORD_LITTLE)
    else $error("byte order not little");

  chk_reserved_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ14
    rd_access |-> O_PRDATA[14:11] == 4'h0 && O_PRDATA[7:3] == 5'h00)
    else $error("reserved bits not zero");

  chk_bad_key_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ13
    bad_key_wr && s_r.wst == WS_IDLE && !s_r.lrst && !s_r.sysrst
    |=> $stable(O_PRI_SPLIT) && !O_CLEAR_ACTIVE && !O_LOCAL_RESET && !O_SYSRESET_REQ)
    else $error("unkeyed write had an effect");

  chk_sysrst_set: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ5
    wr_ok && I_PWDATA[BIT_SYSRST] |=> O_SYSRESET_REQ)
    else $error("reset request not raised");

  chk_warm_follow: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ6
    $rose(O_SYSRESET_REQ) && s_r.wst == WS_IDLE |=> ##[0:1] O_WARM_RESET)
    else $error("warm reset did not follow request");

  chk_warm_length: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ6
    $rose(O_WARM_RESET) |-> O_WARM_RESET[*8] ##1 !O_WARM_RESET)
    else $error("warm reset length wrong");

  chk_warm_clears: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ7
    $fell(O_WARM_RESET) && !$past(wr_ok) |-> !O_SYSRESET_REQ)
    else $error("warm reset left request set");

  chk_clear_pulse: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ8
    wr_ok |=> O_CLEAR_ACTIVE == $past(I_PWDATA[BIT_CLR_ACT]) ##1 (!O_CLEAR_ACTIVE || $past(wr_ok)))
    else $error("clear pulse wrong");

  chk_local_pulse: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ10
    wr_ok |=> O_LOCAL_RESET == $past(I_PWDATA[BIT_LOCAL_RST]))
    else $error("local reset pulse wrong");

  chk_local_readzero: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ11
    rd_access |-> O_PRDATA[BIT_LOCAL_RST] == 1'b0 && O_PRDATA[BIT_CLR_ACT] == 1'b0)
    else $error("action bit read nonzero");

  // the winner index is the current one, the levels are those it was chosen from
  chk_preempt_rule: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ4
    O_PREEMPT |-> O_WIN_VALID && (!$past(I_ACT_VALID) ||
      (O_WIN_IDX == 2'h0 && $past(req_pre[0]) < $past(act_pre)) ||
      (O_WIN_IDX == 2'h1 && $past(req_pre[1]) < $past(act_pre)) ||
      (O_WIN_IDX == 2'h2 && $past(req_pre[2]) < $past(act_pre)) ||
      (O_WIN_IDX == 2'h3 && $past(req_pre[3]) < $past(act_pre))))
    else $error("pre-emption without higher group level");

  chk_win_none: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ4
    I_REQ_PEND == '0 |=> !O_WIN_VALID && !O_PREEMPT)
    else $error("winner reported with nothing pending");

  // the split may only move on a keyed write, a local reset or a finished warm reset
  chk_split_store: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ3
    wr_ok && !s_r.lrst && !warm_last |=> O_PRI_SPLIT == $past(I_PWDATA[SPLIT_MSB:SPLIT_LSB]))
    else $error("split code not stored");

  chk_split_readback: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ3
    rd_access && $stable(O_PRI_SPLIT) |-> O_PRDATA[SPLIT_MSB:SPLIT_LSB] == O_PRI_SPLIT)
    else $error("split code read back wrong");

  chk_key_wr_only: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ13
    !wr_ok && !s_r.lrst && !warm_last |=> $stable(O_PRI_SPLIT))
    else $error("split changed without a keyed write");

  chk_local_split: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ10
    O_LOCAL_RESET |=> O_PRI_SPLIT == SPLIT_RESET)
    else $error("local reset left the split set");

  chk_local_quiet: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ10
    !wr_ok |=> !O_LOCAL_RESET)
    else $error("local reset without a keyed write");

  chk_clear_quiet: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ8
    !wr_ok |=> !O_CLEAR_ACTIVE)
    else $error("clear pulse without a keyed write");

  chk_sysrst_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ5
    O_SYSRESET_REQ && !O_WARM_RESET |=> O_SYSRESET_REQ)
    else $error("reset request dropped before the warm reset");

  chk_warm_idle: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ6
    s_r.wst == WS_IDLE && !O_SYSRESET_REQ |=> !O_WARM_RESET)
    else $error("warm reset without a request");

  chk_unmapped_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_B) // RQ14
    access && !I_PWRITE && !hit |-> O_PRDATA == 32'h0000_0000)
    else $error("unmapped read not zero");

  cov_keyed_write: cover property (@(posedge I_CLK) disable iff (!I_RST_B) wr_ok);
  cov_local:       cover property (@(posedge I_CLK) disable iff (!I_RST_B) O_LOCAL_RESET);
  cov_bad_key:     cover property (@(posedge I_CLK) disable iff (!I_RST_B) bad_key_wr);
  cov_warm:        cover property (@(posedge I_CLK) disable iff (!I_RST_B) $fell(O_WARM_RESET));
  cov_preempt:     cover property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_PREEMPT && O_PRI_SPLIT == 3'h3);

endmodule : airc_ctrl

`default_nettype wire

// *** tb/tb_airc_ctrl.sv ***
// self-checking bench for the interrupt grouping and reset control register
`default_nettype none

module tb_airc_ctrl
  import airc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic                        I_CLK      = 1'b0;
  logic                        I_RST_B    = 1'b0;
  logic                        I_PSEL     = 1'b0;
  logic                        I_PENABLE  = 1'b0;
  logic                        I_PWRITE   = 1'b0;
  logic [ADDR_W-1:0]           I_PADDR    = '0;
  logic [31:0]                 I_PWDATA   = '0;
  logic [NUM_REQ-1:0]          I_REQ_PEND = '0;
  logic [NUM_REQ*PRI_BITS-1:0] I_REQ_PRI  = '0;
  logic                        I_ACT_VALID = 1'b0;
  logic [PRI_BITS-1:0]         I_ACT_PRI  = '0;
  logic [31:0] O_PRDATA;
  logic        O_PREADY, O_PSLVERR, O_WIN_VALID, O_PREEMPT;
  logic [IDX_W-1:0] O_WIN_IDX;
  logic [2:0]  O_PRI_SPLIT;
  logic        O_SYSRESET_REQ, O_WARM_RESET, O_CLEAR_ACTIVE, O_LOCAL_RESET;
  int          error_cnt  = 0;
  int          n_compared = 0;
  int          clr_n = 0, loc_n = 0, warm_n = 0, req_n = 0;
  logic [31:0] rd;
  logic        er;
  logic [2:0]  ew;

  airc_ctrl airc_ctrl_inst (
    .I_CLK          (I_CLK),
    .I_RST_B        (I_RST_B),
    .I_PSEL         (I_PSEL),
    .I_PENABLE      (I_PENABLE),
    .I_PWRITE       (I_PWRITE),
    .I_PADDR        (I_PADDR),
    .I_PWDATA       (I_PWDATA),
    .O_PRDATA       (O_PRDATA),
    .O_PREADY       (O_PREADY),
    .O_PSLVERR      (O_PSLVERR),
    .I_REQ_PEND     (I_REQ_PEND),
    .I_REQ_PRI      (I_REQ_PRI),
    .I_ACT_VALID    (I_ACT_VALID),
    .I_ACT_PRI      (I_ACT_PRI),
    .O_WIN_VALID    (O_WIN_VALID),
    .O_WIN_IDX      (O_WIN_IDX),
    .O_PREEMPT      (O_PREEMPT),
    .O_PRI_SPLIT    (O_PRI_SPLIT),
    .O_SYSRESET_REQ (O_SYSRESET_REQ),
    .O_WARM_RESET   (O_WARM_RESET),
    .O_CLEAR_ACTIVE (O_CLEAR_ACTIVE),
    .O_LOCAL_RESET  (O_LOCAL_RESET)
  );

  // free-running 125 mhz clock
  always #4 I_CLK = ~I_CLK;

  // pulse counters: one-cycle strobes are easy to miss by a late sample
  always @(posedge I_CLK) begin
    if (O_CLEAR_ACTIVE === 1'b1) clr_n <= clr_n + 1;
    if (O_LOCAL_RESET === 1'b1) loc_n <= loc_n + 1;
    if (O_WARM_RESET === 1'b1) warm_n <= warm_n + 1;
    if (O_SYSRESET_REQ === 1'b1) req_n <= req_n + 1;
  end

  task automatic results;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge I_CLK);
    I_PSEL    <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE  <= w;
    I_PADDR   <= a;
    I_PWDATA  <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge I_CLK);
      if (O_PREADY === 1'b1) break;
    end
    if (i == 16) begin
      chk("pready", 32'h1, 32'h0);
      results();
    end
    r = O_PRDATA;
    e = O_PSLVERR;
    I_PSEL    <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] d);
    apb(1'b1, REG_OFF, d, rd, er);
    repeat (2) @(posedge I_CLK);
    #1;
  endtask : wr

  task automatic rdchk(input logic [31:0] exp);
    apb(1'b0, REG_OFF, 32'h0, rd, er);
    chk("readback", exp, rd);
  endtask : rdchk

  // reference winner: lowest pre-emption part, then sub part, then index
  function automatic logic [2:0] exp_win(input logic [2:0] n);
    logic [7:0] m, f, p, s, bp, bs, ap;
    logic [1:0] w;
    m = 8'hff << (n + 1);
    w = 2'h0;
    for (int k = 0; k < 4; k++) begin
      f = {I_REQ_PRI[3*k +: 3], 5'h00};
      p = f & m;
      s = f & ~m;
      if (k == 0 || p < bp || (p == bp && s < bs)) begin
        w  = 2'(k);
        bp = p;
        bs = s;
      end
    end
    ap = {I_ACT_PRI, 5'h00} & m;
    return {bp < ap, w};
  endfunction : exp_win

  initial begin
    repeat (5) @(posedge I_CLK);
    I_RST_B <= 1'b1;
    rdchk(32'hfa050000);
    // requests stay pending while the split is swept
    I_REQ_PEND  <= 4'hf;
    I_REQ_PRI   <= {3'h5, 3'h2, 3'h6, 3'h3};
    I_ACT_VALID <= 1'b1;
    I_ACT_PRI   <= 3'h3;
    for (int n = 0; n < 8; n++) begin
      wr({KEY_UNLOCK, 1'b1, 4'hf, 3'(n), 5'h1f, 3'h0});
      chk("split", 32'(n), 32'(O_PRI_SPLIT));
      rdchk({KEY_READBACK, 5'h00, 3'(n), 8'h00});
      ew = exp_win(3'(n));
      chk("winner", {29'h0, ew}, {29'h0, O_PREEMPT, O_WIN_IDX});
      chk("win valid", 32'h1, 32'(O_WIN_VALID));
    end
    // wrong key: no field change and no action
    wr({16'h05fb, 16'h0107});
    rdchk({KEY_READBACK, 16'h0700});
    chk("no action", 32'h0, 32'(clr_n + loc_n + req_n));
    // unmapped word refuses and ignores the write
    apb(1'b1, 12'h004, {KEY_UNLOCK, 16'h0300}, rd, er);
    chk("slverr", 32'h1, 32'(er));
    apb(1'b0, 12'h004, 32'h0, rd, er);
    chk("unmapped read", 32'h0, rd);
    chk("split kept", 32'h7, 32'(O_PRI_SPLIT));
    wr({KEY_UNLOCK, 16'h0702});
    chk("clear pulses", 32'h1, 32'(clr_n));
    // as software the bench owns the stack; the block is not expected to restore it
    rdchk({KEY_READBACK, 16'h0700});
    wr({KEY_UNLOCK, 16'h0701});
    chk("local pulses", 32'h1, 32'(loc_n));
    rdchk({KEY_READBACK, 16'h0000});
    wr({KEY_UNLOCK, 16'h0500});
    wr({KEY_UNLOCK, 16'h0504});
    chk("reset request", 32'h1, 32'(O_SYSRESET_REQ));
    repeat (14) @(posedge I_CLK);
    #1;
    chk("warm cycles", 32'(WARM_HOLD_CYC), 32'(warm_n));
    chk("request cleared", 32'h0, 32'(O_SYSRESET_REQ));
    chk("split after warm", 32'h0, 32'(O_PRI_SPLIT));
    rdchk({KEY_READBACK, 16'h0000});
    // reset in mid-run must drop the split back and leave no action behind
    wr({KEY_UNLOCK, 16'h0600});
    chk("split before reset", 32'h6, 32'(O_PRI_SPLIT));
    @(posedge I_CLK);
    I_RST_B <= 1'b0;
    repeat (5) @(posedge I_CLK);
    chk("split in reset", 32'(SPLIT_RESET), 32'(O_PRI_SPLIT));
    I_RST_B <= 1'b1;
    rdchk({KEY_READBACK, 16'h0000});
    chk("warm after reset", 32'(WARM_HOLD_CYC), 32'(warm_n));
    chk("stray pulses", 32'h2, 32'(clr_n + loc_n));
    results();
  end

endmodule : tb_airc_ctrl

`default_nettype wire
